//--- hdl/irdct_top.sv
// Dual IR counter/timer: byte timer (transmit, demodulate) and word timer (transmit).
// Assumes a single-cycle register port and asynchronous IR input pins.
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module irdct_top #(
  parameter logic [7:0] CNT_DIV = irdct_pkg::TICK_DIV
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        primary_input_pin_i,
  input  wire logic        comparator_i,
  input  wire logic        ir_amp_i,
  input  wire logic        alternate_input_pin_i,
  output logic             carrier_output_o,
  output logic             envelope_output_o,
  output logic             byte_timeout_irq_o,
  output logic             byte_capture_irq_o,
  output logic             word_timeout_irq_o
);
  // ****************************************
  // Registers and decode
  // ****************************************
  logic [7:0] bctl_q;
  logic [7:0] sctl_q;
  logic [7:0] wctl_q;
  logic [7:0] actl_q;
  logic [7:0] blo_q;
  logic [7:0] bhi_q;
  logic [7:0] wlo_q;
  logic [7:0] whi_q;
  logic [7:0] wcap_lo_q;
  logic [7:0] wcap_hi_q;
  logic [7:0] bcap_lo_q;
  logic [7:0] bcap_hi_q;
  logic [7:0] rdata_q;
  logic [7:0] div_q;
  logic [7:0] cnt8_q;
  logic [15:0] cnt16_q;
  logic       car_q;
  logic       env_q;
  logic [2:0] ecnt_q;
  logic       bto_irq_q;
  logic       bcap_irq_q;
  logic       wto_irq_q;
  irdct_pkg::irdct_dm_e dm_q;
  irdct_pkg::irdct_edge_s in_edge;

  logic wr_bctl;
  logic wr_wctl;
  logic wr_actl;
  logic tick;
  logic src;
  logic demod;
  logic b_start;
  logic b_tx;
  logic b_term;
  logic b_tout_ev;
  logic b_dto;
  logic b_edge;
  logic cap_ev;
  logic cap_last;
  logic w_start;
  logic w_term;
  logic carcap;
  logic force_env;

  assign wr_bctl = wr_i && (addr_i == irdct_pkg::ADDR_BYTE_CTL);
  assign wr_wctl = wr_i && (addr_i == irdct_pkg::ADDR_WORD_CTL);
  assign wr_actl = wr_i && (addr_i == irdct_pkg::ADDR_AUX_CTL);
  assign demod   = bctl_q[irdct_pkg::CT_DEMOD];
  assign carcap  = actl_q[irdct_pkg::AC_CARCAP];

  // ****************************************
  // Counter clock enable
  // ****************************************
  assign tick = (div_q == (CNT_DIV - 8'h01));

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 8'h00;
    end else begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
    end
  end

  // ****************************************
  // Input select and conditioning
  // ****************************************
  always_comb begin
    if (sctl_q[irdct_pkg::SC_ALTSEL]) begin
      src = alternate_input_pin_i;
    end else if (actl_q[irdct_pkg::AC_SRCAMP]) begin
      src = ir_amp_i;
    end else if (actl_q[irdct_pkg::AC_SRCCMP]) begin
      src = comparator_i;
    end else begin
      src = primary_input_pin_i;
    end
  end

  irdct_input_cond u_cond (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .raw_i      (src),
    .filt_sel_i (sctl_q[irdct_pkg::SC_FIELD +: 2]),
    .edge_o     (in_edge)
  );

  assign b_edge = bctl_q[irdct_pkg::CT_EN] && demod &&
                  ((sctl_q[irdct_pkg::SC_EDGE] && in_edge.rise) ||
                   (sctl_q[irdct_pkg::SC_EDGE + 1] && in_edge.fall));

  // ****************************************
  // Byte timer events
  // ****************************************
  assign b_start = wr_bctl && wdata_i[irdct_pkg::CT_EN] && !bctl_q[irdct_pkg::CT_EN];
  assign b_tx    = bctl_q[irdct_pkg::CT_EN] && !demod;
  assign b_term  = b_tx && tick && (cnt8_q == irdct_pkg::CNT8_ONE);
  // Auto-reload flags only when the carrier returns to its initial level
  assign b_tout_ev = b_term && (bctl_q[irdct_pkg::CT_ONESHOT] ||
                     (car_q != sctl_q[irdct_pkg::SC_CINIT]));
  // An edge in the same cycle reloads, so the crossing is not flagged
  assign b_dto = (dm_q == irdct_pkg::DM_COUNT) && bctl_q[irdct_pkg::CT_EN] && demod &&
                 tick && (cnt8_q == irdct_pkg::CNT8_ONE) && !b_edge;
  assign cap_ev   = b_edge && (dm_q == irdct_pkg::DM_COUNT);
  assign cap_last = !carcap || (ecnt_q == irdct_pkg::CARCAP_LAST);

  // ****************************************
  // Byte timer counter and carrier
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt8_q <= 8'h00;
      car_q  <= 1'b0;
    end else if (b_start) begin
      car_q  <= sctl_q[irdct_pkg::SC_CINIT];
      cnt8_q <= sctl_q[irdct_pkg::SC_CINIT] ? bhi_q : blo_q;
    end else if (b_tx && tick) begin
      if (cnt8_q == irdct_pkg::CNT8_ONE) begin
        car_q <= ~car_q;
        if (bctl_q[irdct_pkg::CT_ONESHOT]) begin
          cnt8_q <= 8'h00;
        end else begin
          cnt8_q <= car_q ? blo_q : bhi_q;
        end
      end else begin
        cnt8_q <= cnt8_q - 8'h01;
      end
    end else if (b_edge && (dm_q != irdct_pkg::DM_STOP)) begin
      cnt8_q <= irdct_pkg::CNT8_FULL;
    end else if ((dm_q == irdct_pkg::DM_COUNT) && demod && bctl_q[irdct_pkg::CT_EN] && tick) begin
      cnt8_q <= cnt8_q - 8'h01;
    end
  end

  // ****************************************
  // Demodulation sequencer
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dm_q   <= irdct_pkg::DM_WAIT;
      ecnt_q <= 3'h0;
    end else if (b_start) begin
      dm_q   <= irdct_pkg::DM_WAIT;
      ecnt_q <= 3'h0;
    end else if (b_edge) begin
      case (dm_q)
        irdct_pkg::DM_WAIT: begin
          ecnt_q <= ecnt_q + 3'h1;
          if (!carcap || (ecnt_q == irdct_pkg::CARCAP_SKIP)) begin
            dm_q <= irdct_pkg::DM_COUNT;
          end
        end
        irdct_pkg::DM_COUNT: begin
          ecnt_q <= ecnt_q + 3'h1;
          if (carcap && cap_last) begin
            dm_q <= irdct_pkg::DM_STOP;
          end
        end
        default: begin
          dm_q <= irdct_pkg::DM_STOP;
        end
      endcase
    end
  end

  // Capture registers take no software writes
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bcap_lo_q <= irdct_pkg::RST_CAP;
      bcap_hi_q <= irdct_pkg::RST_CAP;
    end else if (cap_ev && in_edge.rise) begin
      bcap_lo_q <= ~cnt8_q;
    end else if (cap_ev) begin
      bcap_hi_q <= ~cnt8_q;
    end
  end

  // ****************************************
  // Word timer counter and envelope
  // ****************************************
  assign w_start = wr_wctl && wdata_i[irdct_pkg::CT_EN] && !wctl_q[irdct_pkg::CT_EN];
  assign w_term  = wctl_q[irdct_pkg::CT_EN] && tick && (cnt16_q == irdct_pkg::CNT16_ONE);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt16_q <= 16'h0000;
    end else if (w_start) begin
      cnt16_q <= {whi_q, wlo_q};
    end else if (w_term) begin
      cnt16_q <= wctl_q[irdct_pkg::CT_ONESHOT] ? 16'h0000 : {whi_q, wlo_q};
    end else if (wctl_q[irdct_pkg::CT_EN] && tick) begin
      cnt16_q <= cnt16_q - 16'h0001;
    end
  end

  // Envelope holds still under carrier-capture
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      env_q <= 1'b0;
    end else if (carcap) begin
      env_q <= env_q;
    end else if (w_start) begin
      env_q <= sctl_q[irdct_pkg::SC_EINIT];
    end else if (w_term) begin
      env_q <= ~env_q;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bctl_q <= irdct_pkg::RST_CTL;
    end else begin
      if (wr_bctl) begin
        bctl_q <= wdata_i;
      end else if (b_term && bctl_q[irdct_pkg::CT_ONESHOT]) begin
        bctl_q[irdct_pkg::CT_EN] <= 1'b0;
      end
      // Set wins over a write-one clear
      bctl_q[irdct_pkg::CT_TOUT] <= b_tout_ev || b_dto ||
        (bctl_q[irdct_pkg::CT_TOUT] && !(wr_bctl && wdata_i[irdct_pkg::CT_TOUT]));
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wctl_q <= irdct_pkg::RST_CTL;
    end else begin
      if (wr_wctl) begin
        wctl_q <= wdata_i;
      end else if (w_term && wctl_q[irdct_pkg::CT_ONESHOT]) begin
        wctl_q[irdct_pkg::CT_EN] <= 1'b0;
      end
      wctl_q[irdct_pkg::CT_TOUT] <= w_term ||
        (wctl_q[irdct_pkg::CT_TOUT] && !(wr_wctl && wdata_i[irdct_pkg::CT_TOUT]));
    end
  end

  // Edge status bits sit in the aux register, cleared by writing one
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      actl_q <= irdct_pkg::RST_CTL;
    end else begin
      if (wr_actl) begin
        actl_q[7:2] <= wdata_i[7:2];
      end
      actl_q[irdct_pkg::AC_STLO] <= (cap_ev && in_edge.rise) ||
        (actl_q[irdct_pkg::AC_STLO] && !(wr_actl && wdata_i[irdct_pkg::AC_STLO]));
      actl_q[irdct_pkg::AC_STHI] <= (cap_ev && !in_edge.rise) ||
        (actl_q[irdct_pkg::AC_STHI] && !(wr_actl && wdata_i[irdct_pkg::AC_STHI]));
    end
  end

  // Holds may change at any time; the counter sees them at its next load
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sctl_q <= irdct_pkg::RST_CTL;
      blo_q  <= irdct_pkg::RST_HOLD;
      bhi_q  <= irdct_pkg::RST_HOLD;
      wlo_q  <= irdct_pkg::RST_HOLD;
      whi_q  <= irdct_pkg::RST_HOLD;
    end else if (wr_i) begin
      case (addr_i)
        irdct_pkg::ADDR_SHARE_CTL: sctl_q <= wdata_i;
        irdct_pkg::ADDR_BYTE_LO:   blo_q  <= wdata_i;
        irdct_pkg::ADDR_BYTE_HI:   bhi_q  <= wdata_i;
        irdct_pkg::ADDR_WORD_LO:   wlo_q  <= wdata_i;
        irdct_pkg::ADDR_WORD_HI:   whi_q  <= wdata_i;
        default: begin
        end
      endcase
    end
  end

  // Word demodulation is not built, so its captures stay at reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wcap_lo_q <= irdct_pkg::RST_CAP;
      wcap_hi_q <= irdct_pkg::RST_CAP;
    end else begin
      wcap_lo_q <= wcap_lo_q;
      wcap_hi_q <= wcap_hi_q;
    end
  end

  // ****************************************
  // Read port and request pulses
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        irdct_pkg::ADDR_BYTE_CTL:  rdata_q <= bctl_q;
        irdct_pkg::ADDR_SHARE_CTL: rdata_q <= sctl_q;
        irdct_pkg::ADDR_WORD_CTL:  rdata_q <= wctl_q;
        irdct_pkg::ADDR_AUX_CTL:   rdata_q <= actl_q;
        irdct_pkg::ADDR_BYTE_LO:   rdata_q <= blo_q;
        irdct_pkg::ADDR_BYTE_HI:   rdata_q <= bhi_q;
        irdct_pkg::ADDR_WORD_LO:   rdata_q <= wlo_q;
        irdct_pkg::ADDR_WORD_HI:   rdata_q <= whi_q;
        irdct_pkg::ADDR_WCAP_LO:   rdata_q <= wcap_lo_q;
        irdct_pkg::ADDR_WCAP_HI:   rdata_q <= wcap_hi_q;
        irdct_pkg::ADDR_BCAP_LO:   rdata_q <= bcap_lo_q;
        irdct_pkg::ADDR_BCAP_HI:   rdata_q <= bcap_hi_q;
        default:                   rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bto_irq_q  <= 1'b0;
      bcap_irq_q <= 1'b0;
      wto_irq_q  <= 1'b0;
    end else begin
      bto_irq_q  <= (b_tout_ev || b_dto) && bctl_q[irdct_pkg::CT_TOIE];
      bcap_irq_q <= cap_ev && cap_last && bctl_q[irdct_pkg::CT_CAPIE];
      wto_irq_q  <= w_term && wctl_q[irdct_pkg::CT_TOIE];
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // The mode field doubles as filter select while the byte timer demodulates
  assign force_env = !demod && sctl_q[irdct_pkg::SC_FIELD + 1];

  assign rdata_o            = rdata_q;
  assign byte_timeout_irq_o = bto_irq_q;
  assign byte_capture_irq_o = bcap_irq_q;
  assign word_timeout_irq_o = wto_irq_q;
  assign carrier_output_o   = b_tx ? car_q : ~sctl_q[irdct_pkg::SC_CINIT];
  assign envelope_output_o  = force_env ? sctl_q[irdct_pkg::SC_FIELD] :
                              wctl_q[irdct_pkg::CT_EN] ? env_q : ~sctl_q[irdct_pkg::SC_EINIT];

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_carrier_idle_level: assert property (!b_tx |-> carrier_output_o == !sctl_q[irdct_pkg::SC_CINIT])
    else $error("carrier idle level wrong");
  a_byte_start_load: assert property (b_start && !demod |=> car_q == $past(sctl_q[1]) &&
    cnt8_q == ($past(sctl_q[1]) ? $past(bhi_q) : $past(blo_q)))
    else $error("byte start load wrong");
  a_oneshot_stop: assert property (b_term && bctl_q[6] && !wr_bctl |=> !bctl_q[7] && bctl_q[5] &&
    carrier_output_o == !sctl_q[1])
    else $error("one-shot stop wrong");
  a_reload_toggle: assert property (b_term && !bctl_q[6] && !wr_bctl |=> car_q != $past(car_q) &&
    cnt8_q == ($past(car_q) ? $past(blo_q) : $past(bhi_q)))
    else $error("auto-reload step wrong");
  a_zero_wraps: assert property (b_tx && tick && cnt8_q == 8'h00 && !wr_i |=> cnt8_q == 8'hFF &&
    !byte_timeout_irq_o)
    else $error("zero wrap wrong");
  a_capture_value: assert property (cap_ev && in_edge.rise |=> bcap_lo_q == ~$past(cnt8_q) &&
    cnt8_q == 8'hFF && actl_q[0])
    else $error("capture wrong");
  a_demod_timeout: assert property (b_dto && !wr_bctl |=> bctl_q[5] && cnt8_q == 8'h00 ##1
    (cnt8_q == 8'hFF || !$past(tick) || $past(wr_bctl)))
    else $error("demod timeout wrong");
  a_env_forced: assert property (force_env |-> envelope_output_o == sctl_q[2])
    else $error("forced envelope wrong");
  a_env_frozen: assert property (carcap && $past(carcap) |-> $stable(env_q))
    else $error("envelope moved under capture");
  a_word_load: assert property (w_start |=> cnt16_q == {$past(whi_q), $past(wlo_q)})
    else $error("word load wrong");
  a_word_term: assert property (w_term && !wr_wctl |=> wctl_q[5] && (wctl_q[7] == !$past(wctl_q[6])))
    else $error("word terminal wrong");
endmodule
`default_nettype wire

//--- hdl/irdct_pkg.sv
// Constants, types and register map of the dual IR counter/timer.
// Assumes one core clock and a byte-wide register port with 12-bit addresses.
package irdct_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] ADDR_BYTE_CTL  = 12'hD00;
  localparam logic [11:0] ADDR_SHARE_CTL = 12'hD01;
  localparam logic [11:0] ADDR_WORD_CTL  = 12'hD02;
  localparam logic [11:0] ADDR_AUX_CTL   = 12'hD03;
  localparam logic [11:0] ADDR_BYTE_LO   = 12'hD04;
  localparam logic [11:0] ADDR_BYTE_HI   = 12'hD05;
  localparam logic [11:0] ADDR_WORD_LO   = 12'hD06;
  localparam logic [11:0] ADDR_WORD_HI   = 12'hD07;
  localparam logic [11:0] ADDR_WCAP_LO   = 12'hD08;
  localparam logic [11:0] ADDR_WCAP_HI   = 12'hD09;
  localparam logic [11:0] ADDR_BCAP_LO   = 12'hD0A;
  localparam logic [11:0] ADDR_BCAP_HI   = 12'hD0B;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CT_EN     = 7;
  localparam int CT_ONESHOT = 6;
  localparam int CT_TOUT   = 5;
  localparam int CT_DEMOD  = 3;
  localparam int CT_CAPIE  = 2;
  localparam int CT_TOIE   = 1;
  localparam int SC_ALTSEL = 6;
  localparam int SC_EDGE   = 4;
  localparam int SC_FIELD  = 2;
  localparam int SC_CINIT  = 1;
  localparam int SC_EINIT  = 0;
  localparam int AC_SRCAMP = 6;
  localparam int AC_SRCCMP = 5;
  localparam int AC_CARCAP = 4;
  localparam int AC_STHI   = 1;
  localparam int AC_STLO   = 0;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_CTL  = 8'h00;
  localparam logic [7:0] RST_HOLD = 8'h00;
  localparam logic [7:0] RST_CAP  = 8'h00;
  // ****************************************
  // Codes and timing
  // ****************************************
  localparam logic [1:0] EDGE_RISE   = 2'h1;
  localparam logic [1:0] EDGE_FALL   = 2'h2;
  localparam logic [1:0] MODE_FORCE0 = 2'h2;
  localparam logic [1:0] MODE_FORCE1 = 2'h3;
  localparam logic [4:0] FILT_W0 = 5'h01;
  localparam logic [4:0] FILT_W1 = 5'h04;
  localparam logic [4:0] FILT_W2 = 5'h08;
  localparam logic [4:0] FILT_W3 = 5'h10;
  localparam logic [7:0] TICK_DIV = 8'h08;
  localparam logic [7:0] CNT8_FULL = 8'hFF;
  localparam logic [7:0] CNT8_ONE  = 8'h01;
  localparam logic [15:0] CNT16_ONE = 16'h0001;
  localparam logic [2:0] CARCAP_SKIP = 3'h2;
  localparam logic [2:0] CARCAP_LAST = 3'h4;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } irdct_edge_s;

  typedef enum logic [1:0] {
    DM_WAIT  = 2'b00,
    DM_COUNT = 2'b01,
    DM_STOP  = 2'b10
  } irdct_dm_e;
endpackage

//--- hdl/irdct_input_cond.sv
// Input conditioner: synchroniser, glitch filter and edge pulses.
// Assumes the raw input is asynchronous to the core clock.
`timescale 1ns/100ps
`default_nettype none
module irdct_input_cond (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic              raw_i,
  input  wire logic [1:0]        filt_sel_i,
  output var irdct_pkg::irdct_edge_s edge_o
);
  logic       sync1_q;
  logic       sync2_q;
  logic       sync3_q;
  logic       agreed_q;
  logic       filt_q;
  logic [4:0] run_q;
  logic [4:0] width;
  logic       accept;

  always_comb begin
    case (filt_sel_i)
      2'h0:    width = irdct_pkg::FILT_W0;
      2'h1:    width = irdct_pkg::FILT_W1;
      2'h2:    width = irdct_pkg::FILT_W2;
      default: width = irdct_pkg::FILT_W3;
    endcase
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q  <= 1'b0;
      sync2_q  <= 1'b0;
      sync3_q  <= 1'b0;
      agreed_q <= 1'b0;
    end else begin
      sync1_q <= raw_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        agreed_q <= sync3_q;
      end
    end
  end

  // New level must persist for the filter width before it is taken
  assign accept = (agreed_q != filt_q) && ((run_q + 5'h01) >= width);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      filt_q <= 1'b0;
      run_q  <= 5'h00;
    end else if (agreed_q == filt_q) begin
      run_q <= 5'h00;
    end else if (accept) begin
      filt_q <= agreed_q;
      run_q  <= 5'h00;
    end else begin
      run_q <= run_q + 5'h01;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      edge_o <= '0;
    end else begin
      edge_o.level <= accept ? agreed_q : filt_q;
      edge_o.rise  <= accept & agreed_q;
      edge_o.fall  <= accept & ~agreed_q;
    end
  end
endmodule
`default_nettype wire

//--- tb/irdct_ir_source.sv
// Far-side IR source: drives the four input sources from one level.
// Assumes the bench selects the primary pin; other sources show the inverse.
`timescale 1ns/100ps
`default_nettype none
module irdct_ir_source (
  input  wire logic level_i,
  output logic      primary_o,
  output logic      comparator_o,
  output logic      ir_amp_o,
  output logic      alternate_o
);
  // Unselected sources carry the inverse, so a wrong select shows up
  assign primary_o    = level_i;
  assign comparator_o = ~level_i;
  assign ir_amp_o     = ~level_i;
  assign alternate_o  = ~level_i;
endmodule
`default_nettype wire

//--- tb/test_ir_dual_counter_timer.sv
// Self-checking bench for the dual IR counter/timer.
// Assumes the design package, top and the IR source model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_ir_dual_counter_timer;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic [11:0] addr_i     = 12'h000;
  logic [7:0]  wdata_i    = 8'h00;
  logic        wr_i       = 1'b0;
  logic        rd_i       = 1'b0;
  logic        ir_level   = 1'b0;
  logic [7:0]  rdata_o;
  logic        prim, cmp, amp, alt, car, env, btirq, bcirq, wtirq;
  int          errors = 0;
  int          comparisons = 0;
  int          cap_irqs = 0;
  int          n, hi;
  always #4 core_clk_i = ~core_clk_i;
  // Divider of one keeps every count short
  irdct_top #(.CNT_DIV(8'h01)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .primary_input_pin_i(prim),
    .comparator_i(cmp), .ir_amp_i(amp), .alternate_input_pin_i(alt), .carrier_output_o(car),
    .envelope_output_o(env), .byte_timeout_irq_o(btirq), .byte_capture_irq_o(bcirq),
    .word_timeout_irq_o(wtirq));
  irdct_ir_source src (.level_i(ir_level), .primary_o(prim), .comparator_o(cmp), .ir_amp_o(amp),
    .alternate_o(alt));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    // Idle edge, so a following call never reassigns the strobe in one step
    @(posedge core_clk_i);
  endtask
  // Counts capture irq pulses, so an early one cannot slip past
  always @(negedge core_clk_i) begin
    if (bcirq === 1'b1) begin
      cap_irqs++;
    end
  end
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    check($sformatf("reg %h", a), exp, rdata_o);
    @(posedge core_clk_i);
  endtask
  // Bounded wait for one irq pulse; also counts carrier-high cycles
  task automatic wait_pulse(input int sel);
    logic hit;
    n = 0;
    hi = 0;
    hit = 1'b0;
    while (hit !== 1'b1 && n < 400) begin
      @(posedge core_clk_i);
      #1;
      n++;
      hi += int'(car);
      hit = (sel == 0) ? btirq : (sel == 1) ? bcirq : wtirq;
    end
    check("irq pulse", 8'h01, {7'h00, hit});
    @(posedge core_clk_i);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    tally_and_finish;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    check("carrier idle", 8'h01, {7'h00, car});
    check("envelope idle", 8'h01, {7'h00, env});
    for (int a = 0; a < 13; a++) rd(12'hD00 + 12'(a), 8'h00);
    for (int a = 8; a < 12; a++) wr(12'hD00 + 12'(a), 8'hFF);
    for (int a = 8; a < 12; a++) rd(12'hD00 + 12'(a), 8'h00);
    $display("test reset and captures done");
    wr(12'hD01, 8'h08);
    #1 check("envelope force0", 8'h00, {7'h00, env});
    wr(12'hD01, 8'h0C);
    #1 check("envelope force1", 8'h01, {7'h00, env});
    wr(12'hD01, 8'h00);
    $display("test envelope force done");
    wr(12'hD04, 8'h05);
    wr(12'hD05, 8'h09);
    wr(12'hD00, 8'hC2);
    #1 check("carrier start", 8'h00, {7'h00, car});
    wait_pulse(0);
    // The write task's idle edge already spends one tick of the count
    check("low hold load", 8'h04, 8'(n));
    check("carrier toggled", 8'h01, {7'h00, car});
    rd(12'hD00, 8'h62);
    wr(12'hD00, 8'h20);
    rd(12'hD00, 8'h00);
    $display("test byte one-shot done");
    wr(12'hD04, 8'h03);
    wr(12'hD05, 8'h06);
    wr(12'hD00, 8'h82);
    wait_pulse(0);
    check("high reload", 8'h06, 8'(hi));
    check("carrier back", 8'h00, {7'h00, car});
    wr(12'hD00, 8'h00);
    wr(12'hD00, 8'h20);
    rd(12'hD00, 8'h00);
    $display("test byte auto-reload done");
    wr(12'hD04, 8'h00);
    wr(12'hD00, 8'h80);
    repeat (4) @(posedge core_clk_i);
    wr(12'hD00, 8'h00);
    rd(12'hD00, 8'h00);
    $display("test byte zero wrap done");
    wr(12'hD06, 8'h02);
    wr(12'hD07, 8'h01);
    wr(12'hD02, 8'hC2);
    #1 check("envelope start", 8'h00, {7'h00, env});
    wait_pulse(2);
    // High hold times 256 plus low hold, less the idle edge of the write
    check("word load high", 8'h01, 8'(n >> 8));
    check("word load low", 8'h01, 8'(n));
    check("envelope toggled", 8'h01, {7'h00, env});
    rd(12'hD02, 8'h62);
    $display("test word one-shot done");
    wr(12'hD04, 8'hFF);
    wr(12'hD05, 8'hFF);
    wr(12'hD01, 8'h30);
    wr(12'hD00, 8'h8E);
    ir_level <= 1'b1;
    repeat (30) @(posedge core_clk_i);
    ir_level <= 1'b0;
    wait_pulse(1);
    rd(12'hD03, 8'h02);
    // The reload on an edge takes one tick, so 30 cycles capture as 29
    rd(12'hD0B, 8'h1D);
    rd(12'hD0A, 8'h00);
    wait_pulse(0);
    rd(12'hD00, 8'hAE);
    wr(12'hD00, 8'h00);
    wr(12'hD00, 8'h20);
    wr(12'hD03, 8'h02);
    rd(12'hD03, 8'h00);
    $display("test demodulation done");
    wr(12'hD03, 8'h10);
    wr(12'hD00, 8'h8C);
    for (int e = 0; e < 4; e++) begin
      ir_level <= ~ir_level;
      repeat (10) @(posedge core_clk_i);
    end
    check("capture irq early", 8'h01, 8'(cap_irqs));
    ir_level <= ~ir_level;
    wait_pulse(1);
    rd(12'hD0B, 8'h09);
    rd(12'hD0A, 8'h09);
    rd(12'hD03, 8'h13);
    $display("test carrier capture done");
    wr(12'hD02, 8'h20);
    wr(12'hD06, 8'h10);
    wr(12'hD07, 8'h00);
    wr(12'hD02, 8'hC2);
    #1 check("envelope frozen", 8'h01, {7'h00, env});
    wait_pulse(2);
    rd(12'hD02, 8'h62);
    $display("test envelope freeze done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
